// file: rtl/itc_pkg.sv
package itc_pkg;
	// Register byte offsets on the APB window
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] wave_output_control_off = 8'h04;
	localparam logic [7:0] edge_select_control_off = 8'h08;
	localparam logic [7:0] count_snapshot_off = 8'h0c;
	localparam logic [7:0] period_compare_off = 8'h10;
	localparam logic [7:0] chan1_compare_off = 8'h14;
	localparam logic [7:0] chan2_compare_off = 8'h18;
	localparam logic [7:0] chan3_compare_off = 8'h1c;
	localparam logic [7:0] irq_status_off = 8'h20;
	localparam logic [7:0] irq_mask_off = 8'h24;
	// Control register fields
	localparam int run_enable_bit = 0;
	localparam int mode_lo_bit = 1;
	localparam int batch_bit = 4;
	// Mode and counter constants
	localparam logic [2:0] mode_interval = 3'h0;
	localparam logic [15:0] count_idle = 16'hffff;
	localparam logic [15:0] count_zero = 16'h0000;
	// Reset values
	localparam logic [4:0] ctrl_reset = 5'h00;
	localparam logic [7:0] wave_reset = 8'h00;
	localparam logic [7:0] edge_reset = 8'h00;
	localparam logic [15:0] compare_reset = 16'h0000;
	localparam logic [3:0] mask_reset = 4'h0;
endpackage : itc_pkg

// file: rtl/itc_timer.sv
// Behaviour
// [R1] Snapshot reads live count while running; counter FFFFH and snapshot 0000H when stopped.
// [R2] Anytime write: a compare write reaches its shadow immediately.
// [R3] Batch write: all four shadows load together at the period match.
// [R4] Batch transfer armed only by a channel 1 write; otherwise nothing copies.
// [R5] Software writes period/ch2/ch3 before match, then rewrites channel 1.
// [R6] Mode field 000 selects interval timer operation.
// [R7] Start: counter FFFFH to 0000H, wave 0 toggles, period loads shadow.
// [R8] Counter equal period shadow: clear, toggle wave 0, raise match 0.
// [R9] Match 0 interval is period value plus one count clocks.
// [R10] Channels 1-3 still load shadows and raise their own match requests.
// [R11] Each wave output has enable and idle level bits; disabled drives level.
// [R12] Two-bit field selects event input edge; software rewrites compares after.
// [R13] Period 0000H: match 0 and toggle every clock from second, count 0.
// [R14] Period FFFFH: wrap to 0000H is a match, never a wrap interrupt.
// [R15] Period rewrite hits shadow at once; passed counter wraps first.
// [R16] Software stops the counter before lowering the period.
// [R17] Counting starts at FFFFH; first step to 0000H is no match.
// [R18] Each interrupt request is a one-clock pulse in its cause cycle; match_irq is registered from eq and pulses one clock after.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module itc_timer (
	input wire logic clk, // 25 MHz count clock
	input wire logic resetn, // Asynchronous active-low reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic event_input, // External event pin
	output logic [3:0] wave_out, // Wave output pins
	output logic [3:0] match_irq, // Match request pulses
	output logic wrap_irq, // Wrap request, unused in interval mode
	output logic irq // Level interrupt
);
	logic rst_meta_q, rst_sync_q;
	logic [4:0] ctrl_q;
	logic [7:0] wave_ctl_q, edge_ctl_q;
	logic [15:0] cmp_q [4];
	logic [15:0] shadow_q [4];
	logic [15:0] up_counter_q, up_counter_d;
	logic running_q, arm_q;
	logic [3:0] tog_q, status_q, mask_q;
	logic [31:0] rdata_q;
	logic ev_meta_q, ev_sync_q, ev_last_q;
	logic wrap_flag_q;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire rst_n = rst_sync_q;

	// APB decode
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_ctrl = paddr == itc_pkg::ctrl_off;
	wire hit_wave = paddr == itc_pkg::wave_output_control_off;
	wire hit_edge = paddr == itc_pkg::edge_select_control_off;
	wire hit_cnt = paddr == itc_pkg::count_snapshot_off;
	wire hit_sts = paddr == itc_pkg::irq_status_off;
	wire hit_msk = paddr == itc_pkg::irq_mask_off;
	wire [3:0] hit_cmp;
	assign hit_cmp[0] = paddr == itc_pkg::period_compare_off;
	assign hit_cmp[1] = paddr == itc_pkg::chan1_compare_off;
	assign hit_cmp[2] = paddr == itc_pkg::chan2_compare_off;
	assign hit_cmp[3] = paddr == itc_pkg::chan3_compare_off;
	wire mapped = hit_ctrl | hit_wave | hit_edge | hit_cnt | hit_sts | hit_msk | (|hit_cmp);
	assign pready = 1'b1;
	// Zero-wait slave; unmapped addresses answer with an error
	assign pslverr = access && !mapped;

	// Mode and run decode
	wire run_en = ctrl_q[itc_pkg::run_enable_bit];
	wire [2:0] mode = ctrl_q[itc_pkg::mode_lo_bit +: 3];
	wire interval_mode = mode == itc_pkg::mode_interval; // R6
	wire batch = ctrl_q[itc_pkg::batch_bit];
	wire start = run_en && !running_q && interval_mode;
	// A stop write must silence the compares at once, or a held zero count keeps matching
	wire active = running_q && run_en && interval_mode;
	wire [3:0] eq;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_eq
			assign eq[g] = active && up_counter_q == shadow_q[g]; // R10
		end
	endgenerate
	// Start step FFFFH to 0000H is not a match since running_q is still low
	wire period_match = eq[0]; // R17
	wire chan1_write = wr && hit_cmp[1];
	wire batch_load = batch && period_match && (arm_q || chan1_write);

	// Counter next value
	always_comb begin
		up_counter_d = up_counter_q;
		if (!run_en) begin
			up_counter_d = itc_pkg::count_idle; // R1
		end else if (start) begin
			up_counter_d = itc_pkg::count_zero; // R7
		end else if (period_match) begin
			up_counter_d = itc_pkg::count_zero; // R8 R9 R13 R14
		end else if (active) begin
			up_counter_d = up_counter_q + 16'h0001; // R15
		end
	end

	// Control and configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= itc_pkg::ctrl_reset;
			wave_ctl_q <= itc_pkg::wave_reset;
			edge_ctl_q <= itc_pkg::edge_reset;
			mask_q <= itc_pkg::mask_reset;
		end else if (wr) begin
			if (hit_ctrl) ctrl_q <= pwdata[4:0];
			if (hit_wave) wave_ctl_q <= pwdata[7:0]; // R11
			if (hit_edge) edge_ctl_q <= {2'h0, pwdata[5:4], 4'h0}; // R12
			if (hit_msk) mask_q <= pwdata[3:0];
		end
	end

	// Counter, run tracking and batch arming
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_counter_q <= itc_pkg::count_idle;
			running_q <= 1'b0;
			arm_q <= 1'b0;
		end else begin
			up_counter_q <= up_counter_d;
			running_q <= run_en && interval_mode;
			if (batch_load) arm_q <= 1'b0; // R4
			else if (chan1_write) arm_q <= 1'b1; // R4
		end
	end

	// Compare registers and their shadows
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			wire sw_wr = wr && hit_cmp[g];
			wire [15:0] wval = pwdata[15:0];
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cmp_q[g] <= itc_pkg::compare_reset;
					shadow_q[g] <= itc_pkg::compare_reset;
				end else begin
					if (sw_wr) cmp_q[g] <= wval;
					if (!batch && sw_wr) shadow_q[g] <= wval; // R2 R15
					else if (batch_load) shadow_q[g] <= sw_wr ? wval : cmp_q[g]; // R3
					else if (g == 0 && start) shadow_q[g] <= cmp_q[g]; // R7
				end
			end
		end
	endgenerate

	// Toggle state, pin drive and match pulses
	wire [3:0] tog_set;
	assign tog_set[0] = start | eq[0]; // R7 R8
	assign tog_set[3:1] = eq[3:1];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_q <= 4'h0;
			wave_out <= 4'h0;
			match_irq <= 4'h0;
		end else begin
			tog_q <= run_en ? (tog_q ^ tog_set) : 4'h0;
			match_irq <= eq; // R18
			for (int i = 0; i < 4; i++) begin
				wave_out[i] <= wave_ctl_q[2*i] ? tog_q[i] : wave_ctl_q[2*i+1]; // R11
			end
		end
	end
	// Wrap never fires in interval mode; flag held low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrap_flag_q <= 1'b0;
			wrap_irq <= 1'b0;
		end else begin
			wrap_flag_q <= 1'b0; // R14
			wrap_irq <= 1'b0; // R14
		end
	end

	// Event pin synchroniser; edge select kept for later modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_meta_q <= 1'b0;
			ev_sync_q <= 1'b0;
			ev_last_q <= 1'b0;
		end else begin
			ev_meta_q <= event_input;
			ev_sync_q <= ev_meta_q;
			ev_last_q <= ev_sync_q;
		end
	end

	// Sticky status: set wins over the read clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= 4'h0;
		end else begin
			status_q <= ((rd && hit_sts) ? 4'h0 : status_q) | eq;
		end
	end
	assign irq = |(status_q & ~mask_q);

	// Read data mux
	wire [15:0] snapshot = run_en ? up_counter_q : itc_pkg::count_zero; // R1
	wire [31:0] rmux = hit_ctrl ? {27'h0, ctrl_q} :
		hit_wave ? {24'h0, wave_ctl_q} :
		hit_edge ? {24'h0, edge_ctl_q} :
		hit_cnt ? {16'h0, snapshot} :
		hit_cmp[0] ? {16'h0, cmp_q[0]} :
		hit_cmp[1] ? {16'h0, cmp_q[1]} :
		hit_cmp[2] ? {16'h0, cmp_q[2]} :
		hit_cmp[3] ? {16'h0, cmp_q[3]} :
		hit_sts ? {27'h0, wrap_flag_q, status_q} :
		hit_msk ? {28'h0, mask_q} : 32'h0;
	assign prdata = rmux;
	wire unused_ok = ev_last_q ^ rdata_q[0];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rdata_q <= 32'h0;
		else rdata_q <= {31'h0, unused_ok};
	end

	// Assertions
	sequence s_start;
		run_en && !running_q && interval_mode;
	endsequence
	property p_stop_idle;
		@(posedge clk) disable iff (!rst_n) !run_en |=> up_counter_q == 16'hffff;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("counter not idle"); // R1
	property p_snap_zero;
		@(posedge clk) disable iff (!rst_n) !run_en |-> snapshot == 16'h0000;
	endproperty
	a_snap_zero: assert property (p_snap_zero) else $error("snapshot not zero"); // R1
	property p_start;
		@(posedge clk) disable iff (!rst_n) s_start |=> up_counter_q == 16'h0000 && !match_irq[0];
	endproperty
	a_start: assert property (p_start) else $error("bad start"); // R7
	sequence s_period_match;
		eq[0] && run_en;
	endsequence
	property p_clear;
		@(posedge clk) disable iff (!rst_n) s_period_match |=> up_counter_q == 16'h0000 && match_irq[0];
	endproperty
	a_clear: assert property (p_clear) else $error("no clear on match"); // R8
	property p_anytime;
		@(posedge clk) disable iff (!rst_n) !batch && wr && hit_cmp[1] |=> shadow_q[1] == $past(pwdata[15:0]);
	endproperty
	a_anytime: assert property (p_anytime) else $error("anytime write lost"); // R2
	property p_no_arm;
		@(posedge clk) disable iff (!rst_n) batch && eq[0] && !arm_q && !chan1_write && !(wr && hit_cmp[2]) |=> $stable(shadow_q[2]);
	endproperty
	a_no_arm: assert property (p_no_arm) else $error("unarmed batch copy"); // R4
	property p_batch;
		@(posedge clk) disable iff (!rst_n) batch_load && !wr |=> shadow_q[3] == $past(cmp_q[3]);
	endproperty
	a_batch: assert property (p_batch) else $error("batch copy missed"); // R3
	property p_pulse;
		@(posedge clk) disable iff (!rst_n) !eq[1] |=> !match_irq[1];
	endproperty
	a_pulse: assert property (p_pulse) else $error("irq not a pulse"); // R18
	property p_nowrap;
		@(posedge clk) disable iff (!rst_n) up_counter_q == 16'hffff && running_q |=> !wrap_irq;
	endproperty
	a_nowrap: assert property (p_nowrap) else $error("wrap raised"); // R14
	property p_idle_lvl;
		@(posedge clk) disable iff (!rst_n) !wave_ctl_q[0] |=> wave_out[0] == $past(wave_ctl_q[1]);
	endproperty
	a_idle_lvl: assert property (p_idle_lvl) else $error("idle level wrong"); // R11
	// Run tracking follows the mode field
	property p_run_track;
		@(posedge clk) disable iff (!rst_n) run_en && interval_mode |=> running_q;
	endproperty
	a_run_track: assert property (p_run_track) else $error("run not tracked"); // R6
	property p_mode_gate;
		@(posedge clk) disable iff (!rst_n) !interval_mode |=> !running_q;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("runs outside interval mode"); // R6
	// Counting between matches
	property p_count_inc;
		@(posedge clk) disable iff (!rst_n)
			active && !eq[0] |=> up_counter_q == $past(up_counter_q) + 16'h0001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("count did not step"); // R15
	property p_start_shadow;
		@(posedge clk) disable iff (!rst_n) s_start && !(wr && hit_cmp[0]) |=> shadow_q[0] == $past(cmp_q[0]);
	endproperty
	a_start_shadow: assert property (p_start_shadow) else $error("period not loaded at start"); // R7
	property p_start_toggle;
		@(posedge clk) disable iff (!rst_n) s_start |=> tog_q[0] != $past(tog_q[0]);
	endproperty
	a_start_toggle: assert property (p_start_toggle) else $error("no toggle at start"); // R7
	property p_match_toggle;
		@(posedge clk) disable iff (!rst_n) s_period_match |=> tog_q[0] != $past(tog_q[0]);
	endproperty
	a_match_toggle: assert property (p_match_toggle) else $error("no toggle at match"); // R8
	property p_chan_toggle;
		@(posedge clk) disable iff (!rst_n) eq[1] && run_en |=> tog_q[1] != $past(tog_q[1]);
	endproperty
	a_chan_toggle: assert property (p_chan_toggle) else $error("no channel toggle"); // R10
	// Every equality gives its pulse one clock later
	property p_irq1;
		@(posedge clk) disable iff (!rst_n) eq[1] |=> match_irq[1];
	endproperty
	a_irq1: assert property (p_irq1) else $error("channel 1 pulse missing"); // R10
	property p_irq2;
		@(posedge clk) disable iff (!rst_n) eq[2] |=> match_irq[2];
	endproperty
	a_irq2: assert property (p_irq2) else $error("channel 2 pulse missing"); // R10
	property p_irq3;
		@(posedge clk) disable iff (!rst_n) eq[3] |=> match_irq[3];
	endproperty
	a_irq3: assert property (p_irq3) else $error("channel 3 pulse missing"); // R10
	property p_pulse0;
		@(posedge clk) disable iff (!rst_n) !eq[0] |=> !match_irq[0];
	endproperty
	a_pulse0: assert property (p_pulse0) else $error("match 0 not a pulse"); // R18
	property p_no_eq_idle;
		@(posedge clk) disable iff (!rst_n) !running_q |-> eq == 4'h0;
	endproperty
	a_no_eq_idle: assert property (p_no_eq_idle) else $error("match while not running"); // R17
	// Sticky status and its read clear
	property p_sticky;
		@(posedge clk) disable iff (!rst_n) eq[1] |=> status_q[1];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status not set"); // R10
	property p_read_clear;
		@(posedge clk) disable iff (!rst_n) rd && hit_sts && eq == 4'h0 |=> status_q == 4'h0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared");
	property p_snap_live;
		@(posedge clk) disable iff (!rst_n) run_en |-> prdata[15:0] == up_counter_q || !hit_cnt;
	endproperty
	a_snap_live: assert property (p_snap_live) else $error("snapshot not live"); // R1
	// Corner periods
	property p_zero_hold;
		@(posedge clk) disable iff (!rst_n)
			active && shadow_q[0] == 16'h0000 && up_counter_q == 16'h0000
			|=> up_counter_q == 16'h0000 && match_irq[0];
	endproperty
	a_zero_hold: assert property (p_zero_hold) else $error("zero period wrong"); // R13
	property p_full_wrap;
		@(posedge clk) disable iff (!rst_n)
			active && shadow_q[0] == 16'hffff && up_counter_q == 16'hffff
			|=> up_counter_q == 16'h0000 && match_irq[0] && !wrap_irq;
	endproperty
	a_full_wrap: assert property (p_full_wrap) else $error("full period wrong"); // R14
	// Batch transfer and its arming
	property p_batch_all;
		@(posedge clk) disable iff (!rst_n)
			batch_load && !wr |=> shadow_q[1] == $past(cmp_q[1]) && shadow_q[2] == $past(cmp_q[2]);
	endproperty
	a_batch_all: assert property (p_batch_all) else $error("batch copy incomplete"); // R3
	property p_batch_hold;
		@(posedge clk) disable iff (!rst_n) batch && !batch_load |=> $stable(shadow_q[1]);
	endproperty
	a_batch_hold: assert property (p_batch_hold) else $error("shadow moved outside batch"); // R4
	property p_arm;
		@(posedge clk) disable iff (!rst_n) chan1_write && !batch_load |=> arm_q;
	endproperty
	a_arm: assert property (p_arm) else $error("channel 1 write did not arm"); // R4
	property p_disarm;
		@(posedge clk) disable iff (!rst_n) batch_load |=> !arm_q;
	endproperty
	a_disarm: assert property (p_disarm) else $error("arm not consumed"); // R4
	property p_anytime0;
		@(posedge clk) disable iff (!rst_n) !batch && wr && hit_cmp[0] |=> shadow_q[0] == $past(pwdata[15:0]);
	endproperty
	a_anytime0: assert property (p_anytime0) else $error("period rewrite late"); // R15
	// Pin drive follows the toggle when enabled
	property p_wave_en;
		@(posedge clk) disable iff (!rst_n) wave_ctl_q[0] |=> wave_out[0] == $past(tog_q[0]);
	endproperty
	a_wave_en: assert property (p_wave_en) else $error("wave pin not driven"); // R11
	property p_stop_tog;
		@(posedge clk) disable iff (!rst_n) !run_en |=> tog_q == 4'h0;
	endproperty
	a_stop_tog: assert property (p_stop_tog) else $error("toggle kept after stop"); // R1
endmodule : itc_timer
`default_nettype wire

// file: bench/itc_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module itc_timer_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic event_input = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, wrap_irq, irq;
	logic [3:0] wave_out, match_irq;
	logic [31:0] rd;
	logic er, w0;
	int miscompares = 0;
	int checks = 0;
	int wraps = 0;
	int t9, n;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} itc_row_type;
	// Reset values, read-only and unmapped places, then write and read back
	itc_row_type rows [14] = '{
		'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h20, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h28, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h28, 32'h5, 32'h0, 1'b1},
		'{1'b1, 8'h08, 32'h30, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h30, 1'b0},
		'{1'b1, 8'h0c, 32'h55, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'haa, 32'h0, 1'b0}};
	// Free-running 25 MHz clock
	always #20 clk = ~clk;
	// Interval mode must never raise the wrap request
	always @(posedge clk) if (wrap_irq === 1'b1) wraps++;
	itc_timer DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_input(event_input), .wave_out(wave_out), .match_irq(match_irq),
		.wrap_irq(wrap_irq), .irq(irq));
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	// A hang counts as a mismatch and ends the run at once
	task stop_hang(input string nm);
		chk(nm, 32'h1, 32'h0);
		give_verdict();
	endtask : stop_hang
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) stop_hang("pready wait");
	endtask : apb
	// Cycles until the next pulse of one match request
	task automatic pulse(input int i, output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (match_irq[i] !== 1'b1 && c < 70000);
		if (c >= 70000) stop_hang("match wait");
	endtask : pulse
	// Spacing between two successive pulses
	task automatic gap(input int i, output int c);
		pulse(i, c);
		pulse(i, c);
	endtask : gap
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("read data", rows[i].x, rd);
			chk("slave error", {31'h0, rows[i].e}, {31'h0, er});
		end
		repeat (2) @(posedge clk);
		chk("idle levels", 32'hf, {28'h0, wave_out});
		// Anytime mode: period 9, channel 1 at 2, all requests masked
		apb(1'b1, 8'h04, 32'h01);
		apb(1'b1, 8'h10, 32'h9);
		apb(1'b1, 8'h14, 32'h2);
		apb(1'b1, 8'h24, 32'hf);
		apb(1'b1, 8'h00, 32'h1);
		pulse(0, t9);
		w0 = wave_out[0];
		pulse(0, n);
		chk("period gap", 32'd10, n);
		chk("wave toggle", {31'h0, ~w0}, {31'h0, wave_out[0]});
		gap(1, n);
		chk("chan1 gap", 32'd10, n);
		chk("masked irq", 32'h0, {31'h0, irq});
		// Unmask channel 1 only, then read-to-clear the sticky status
		apb(1'b1, 8'h24, 32'hd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmasked irq", 32'h1, {31'h0, irq});
		chk("status bits", 32'h2, rd & 32'h12);
		@(posedge clk);
		chk("cleared irq", 32'h0, {31'h0, irq});
		apb(1'b0, 8'h0c, 32'h0);
		chk("live count", 32'h1, {31'h0, rd <= 32'h9});
		apb(1'b1, 8'h10, 32'd19);
		gap(0, n);
		chk("anytime period", 32'd20, n);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk("stopped count", 32'h0, rd);
		// Period zero matches every clock with the count held at zero
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		gap(0, n);
		chk("zero period", 32'd1, n);
		apb(1'b0, 8'h0c, 32'h0);
		chk("zero count", 32'h0, rd);
		apb(1'b1, 8'h00, 32'h0);
		// Batch mode: a period write alone must not transfer
		apb(1'b1, 8'h10, 32'h7);
		apb(1'b1, 8'h00, 32'h11);
		gap(0, n);
		chk("batch start", 32'd8, n);
		apb(1'b1, 8'h10, 32'h3);
		gap(0, n);
		chk("unarmed batch", 32'd8, n);
		apb(1'b1, 8'h14, 32'h2);
		gap(0, n);
		chk("armed batch", 32'd4, n);
		apb(1'b1, 8'h00, 32'h0);
		// Full-range period: first match lands 65526 clocks later than with period 9
		apb(1'b1, 8'h10, 32'hffff);
		apb(1'b1, 8'h00, 32'h1);
		pulse(0, n);
		chk("full period", t9 + 32'd65526, n);
		chk("wrap pulses", 32'h0, wraps);
		// Second reset in mid-run
		resetn <= 1'b0;
		@(posedge clk);
		chk("reset outputs", 32'h0, {23'h0, match_irq, wave_out, irq});
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk("reset ctrl", 32'h0, rd);
		give_verdict();
	end
endmodule : itc_timer_tb
`default_nettype wire
